/* File: dv/pst_sensor_model.sv */
// Purpose: Image sensor side model that times the restore and acquire pulses
// Assumes: Pulses are sampled on the rising edge of the shared clock
// Notes:   Reports the last rise time and last completed width of each pulse
`default_nettype none

module pst_sensor_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pulses from the timing block
  input wire pst_pkg::pst_pulses_s pulses,
  // Measurements
  output logic [31:0] acq_rise,
  output logic [7:0] acq_width,
  output logic [31:0] rst_rise,
  output logic [7:0] rst_width
);
  import pst_pkg::*;

  // ----------------------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------------------
  logic [31:0] cyc;
  logic [7:0] acq_cnt;
  logic [7:0] rst_cnt;
  logic acq_q;
  logic rst_q;

  // Stamp each rise, count high cycles, keep width at each fall
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cyc <= '0;
      acq_cnt <= '0;
      rst_cnt <= '0;
      acq_q <= 1'b0;
      rst_q <= 1'b0;
      acq_rise <= '0;
      rst_rise <= '0;
      acq_width <= '0;
      rst_width <= '0;
    end else begin
      cyc <= cyc + 32'h1;
      acq_q <= pulses.acquire;
      rst_q <= pulses.restore;
      if (pulses.acquire && !acq_q) begin
        acq_rise <= cyc;
      end
      if (pulses.restore && !rst_q) begin
        rst_rise <= cyc;
      end
      if (!pulses.acquire && acq_q) begin
        acq_width <= acq_cnt;
      end
      if (!pulses.restore && rst_q) begin
        rst_width <= rst_cnt;
      end
      acq_cnt <= pulses.acquire ? (acq_q ? acq_cnt + 8'h01 : 8'h01) : 8'h00;
      rst_cnt <= pulses.restore ? (rst_q ? rst_cnt + 8'h01 : 8'h01) : 8'h00;
    end
  end

endmodule

`default_nettype wire

/* File: dv/pst_timing_tb.sv */
// Purpose: Self-checking bench of the sampling timing registers and pulses
// Assumes: One 40 MHz clock; asynchronous active-high reset
// Notes:   Pulse widths and offsets are measured by the sensor model
`default_nettype none
`include "pst_consts.svh"

module pst_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pst_pkg::*;

  // ----------------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  pst_bus_s bus = '0;
  logic [7:0] rd_data;
  pst_pulses_s pulses;
  logic [2:0] clock_band;
  logic [1:0] loop_band;
  logic sample_hold, loop_reset, loop_locked, false_lock, irq;
  logic [31:0] acq_rise, rst_rise;
  logic [7:0] acq_width, rst_width;
  int bad_count = 0;
  int num_checks = 0;

  pst_timing dut (.clock(clock), .rst(rst), .bus(bus), .rd_data(rd_data), .pulses(pulses),
    .clock_band(clock_band), .loop_band(loop_band), .sample_hold(sample_hold),
    .loop_reset(loop_reset), .loop_locked(loop_locked), .false_lock(false_lock), .irq(irq));

  pst_sensor_model sensor (.clock(clock), .rst(rst), .pulses(pulses), .acq_rise(acq_rise),
    .acq_width(acq_width), .rst_rise(rst_rise), .rst_width(rst_width));

  // Clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // Bounded wait for the loop to settle either way
  task automatic wait_lock();
    int i;
    repeat (3) @(posedge clock);
    for (i = 0; i < 200 && loop_locked !== 1'b1 && false_lock !== 1'b1; i++) begin
      @(posedge clock);
    end
    #1;
    if (i == 200) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      finish_test();
    end
  endtask

  task automatic relock();
    wr(`PST_OFS_LOOP_CFG, 8'h01);
    wait_cyc(2);
    chk({7'h0, loop_reset}, 8'h01);
    wait_lock();
    chk({7'h0, loop_reset}, 8'h00);
  endtask

  // Counts high cycles of one pulse over a little more than a period
  task automatic watch_low(input bit acq);
    int n;
    n = 0;
    repeat (70) begin
      @(posedge clock);
      #1;
      if ((acq ? pulses.acquire : pulses.restore) !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    logic [5:0] ad[8] = '{6'h06, 6'h07, 6'h20, 6'h21, 6'h22, 6'h23, 6'h25, 6'h3f};
    logic [7:0] ex[8] = '{8'h81, 8'h00, 8'h08, 8'h1c, 8'h28, 8'h3c, 8'h02, 8'h00};
    chk({5'h0, clock_band}, 8'h00);
    chk({6'h0, loop_band}, 8'h02);
    chk({7'h0, sample_hold}, 8'h01);
    chk({7'h0, loop_reset}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rchk(ad[i], ex[i]);
    end
    wait_lock();
    chk({7'h0, loop_locked}, 8'h01);
    rchk(`PST_OFS_LOOP_CFG, 8'h0e);
    $display("test reset done");
  endtask

  task automatic t_masks();
    for (int i = 0; i < 4; i++) begin
      wr(6'h20 + 6'(i), 8'hff);
      rchk(6'h20 + 6'(i), 8'h3f);
    end
    wr(`PST_OFS_BAND, 8'hff);
    rchk(`PST_OFS_BAND, 8'h73);
    wr(`PST_OFS_STATUS, 8'hff);
    rchk(`PST_OFS_STATUS, 8'h00);
    wr(6'h3f, 8'hff);
    rchk(6'h3f, 8'h00);
    wr(`PST_OFS_RISE_R, 8'h08);
    wr(`PST_OFS_FALL_R, 8'h1c);
    wr(`PST_OFS_RISE_A, 8'h28);
    wr(`PST_OFS_FALL_A, 8'h3c);
    wr(`PST_OFS_BAND, 8'h02);
    $display("test masks done");
  endtask

  task automatic t_irq();
    rchk(`PST_OFS_IRQ_STAT, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(`PST_OFS_IRQ_MASK, 8'h01);
    wait_cyc(2);
    chk({7'h0, irq}, 8'h01);
    wr(`PST_OFS_IRQ_STAT, 8'h01);
    wait_cyc(2);
    chk({7'h0, irq}, 8'h00);
    rchk(`PST_OFS_IRQ_STAT, 8'h00);
    $display("test irq done");
  endtask

  task automatic t_bands();
    logic [1:0] lb[6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
    for (int i = 0; i < 6; i++) begin
      wr(`PST_OFS_BAND, {1'b0, 3'(i), 2'b00, lb[i]});
      relock();
      chk({5'h0, clock_band}, 8'(i));
      chk({6'h0, loop_band}, {6'h0, lb[i]});
      chk({6'h0, loop_locked, false_lock}, 8'h02);
    end
    $display("test bands done");
  endtask

  task automatic t_false();
    logic [7:0] bd[2] = '{8'h60, 8'h00};
    wr(`PST_OFS_IRQ_MASK, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(`PST_OFS_BAND, bd[i]);
      relock();
      chk({6'h0, loop_locked, false_lock}, 8'h01);
      rchk(`PST_OFS_STATUS, 8'h01);
    end
    wr(`PST_OFS_IRQ_STAT, 8'h03);
    relock();
    rchk(`PST_OFS_IRQ_STAT, 8'h02);
    wr(`PST_OFS_IRQ_MASK, 8'h02);
    wait_cyc(2);
    chk({7'h0, irq}, 8'h01);
    wr(`PST_OFS_IRQ_STAT, 8'h02);
    wait_cyc(2);
    chk({7'h0, irq}, 8'h00);
    wr(`PST_OFS_BAND, 8'h02);
    relock();
    rchk(`PST_OFS_STATUS, 8'h00);
    $display("test false lock done");
  endtask

  task automatic t_pulses();
    logic [5:0] rs[3] = '{6'd10, 6'd60, 6'd0};
    logic [5:0] fs[3] = '{6'd12, 6'd4, 6'd63};
    logic [7:0] ws[3] = '{8'd2, 8'd8, 8'd63};
    wr(`PST_OFS_SH_MODE, 8'h00);
    wait_cyc(130);
    chk(rst_width, 8'd20);
    chk(acq_width, 8'd20);
    chk({2'b00, 6'(acq_rise - rst_rise)}, 8'h20);
    for (int i = 0; i < 3; i++) begin
      wr(`PST_OFS_RISE_A, {2'b00, rs[i]});
      wr(`PST_OFS_FALL_A, {2'b00, fs[i]});
      wait_cyc(130);
      chk(acq_width, ws[i]);
    end
    wr(`PST_OFS_RISE_R, 8'h21);
    wr(`PST_OFS_FALL_R, 8'h24);
    wait_cyc(130);
    chk(rst_width, 8'd3);
    chk({2'b00, 6'(acq_rise - rst_rise)}, 8'h1f);
    wr(`PST_OFS_RISE_A, 8'h05);
    wr(`PST_OFS_FALL_A, 8'h05);
    // A pulse already open only closes on its fall phase, up to a period later
    wait_cyc(66);
    watch_low(1'b1);
    wr(`PST_OFS_SH_MODE, 8'h80);
    wait_cyc(2);
    chk({7'h0, sample_hold}, 8'h01);
    watch_low(1'b0);
    $display("test pulses done");
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset();
    t_masks();
    t_irq();
    t_bands();
    t_false();
    t_pulses();
    finish_test();
  end

endmodule

`default_nettype wire

/* File: rtl/pst_consts.svh */
// Purpose: Named constants of the pixel sampling timing configuration block
// Assumes: Included by its bare name from every design file that needs it
// Notes:   Types live in pst_pkg; this file holds offsets, fields, resets, timing
//
// Overview of operation
// - Restore pulse rise position is the 6-bit index in bits 5:0, 0..63.
// - Restore pulse fall position is a second 6-bit index in bits 5:0, 0..63.
// - Restore pulse indices act only in correlated double sampling mode.
// - Acquire pulse rise position is a 6-bit index in bits 5:0, 0..63.
// - Acquire pulse fall position is a 6-bit index in bits 5:0, 0..63.
// - Clock band field bits 6:4 picks the input pixel clock frequency band.
// - Loop range field bits 1:0 picks the delay-locked loop frequency band.
// - Writing one to loop config bit 0 resets the loop; bit self-clears.
// - Mode register bit 7 high selects sample-and-hold, low correlated double sampling.
// - Read-only status bit 0 reports a half-frequency false lock.
`ifndef PST_CONSTS_SVH
`define PST_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PST_ADDR_W 6
`define PST_OFS_SH_MODE 6'h06
`define PST_OFS_STATUS 6'h07
`define PST_OFS_RISE_R 6'h20
`define PST_OFS_FALL_R 6'h21
`define PST_OFS_RISE_A 6'h22
`define PST_OFS_FALL_A 6'h23
`define PST_OFS_BAND 6'h25
`define PST_OFS_LOOP_CFG 6'h28
`define PST_OFS_IRQ_STAT 6'h30
`define PST_OFS_IRQ_MASK 6'h31

// ----------------------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------------------
`define PST_RST_SH_MODE 8'h81
`define PST_RST_RISE_R 8'h08
`define PST_RST_FALL_R 8'h1c
`define PST_RST_RISE_A 8'h28
`define PST_RST_FALL_A 8'h3c
`define PST_RST_BAND 8'h02
`define PST_RST_LOOP_CFG 8'h0f
`define PST_RST_IRQ 8'h00
`define PST_MASK_IDX 8'h3f
`define PST_MASK_SH_MODE 8'h87
`define PST_MASK_BAND 8'h73
`define PST_MASK_IRQ 8'h03

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PST_IDX_MSB 5
`define PST_SH_BIT 7
`define PST_BAND_MSB 6
`define PST_BAND_LSB 4
`define PST_LOOP_MSB 1
`define PST_LOOP_LSB 0
`define PST_LOOP_RST_BIT 0
`define PST_FLOCK_BIT 0
`define PST_IRQ_LOCK_BIT 0
`define PST_IRQ_FLOCK_BIT 1

// ----------------------------------------------------------------------------
// Band codes
// ----------------------------------------------------------------------------
`define PST_BAND_25_40 3'h0
`define PST_BAND_14_25 3'h1
`define PST_BAND_10_14 3'h2
`define PST_BAND_7P5_10 3'h3
`define PST_BAND_6_7P5 3'h4
`define PST_BAND_5_6 3'h5
`define PST_LOOP_14_40 2'h2
`define PST_LOOP_7P5_14 2'h1
`define PST_LOOP_5_7P5 2'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PST_CLK_NS 25
`define PST_LOOP_RST_NS 100
`define PST_LOCK_NS 1000
`define PST_LOOP_RST_CYC ((`PST_LOOP_RST_NS + `PST_CLK_NS - 1) / `PST_CLK_NS)
`define PST_LOCK_CYC (`PST_LOCK_NS / `PST_CLK_NS)
`define PST_CNT_W 6

`endif

/* File: rtl/pst_edge_gen.sv */
// Purpose: One timing pulse placed by a rise and a fall phase index
// Assumes: Phase counts 0..63 across one pixel period
// Notes:   Equal indices give no pulse; rise above fall wraps the period
`default_nettype none
`include "pst_consts.svh"

module pst_edge_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Placement
  input wire logic enable,
  input wire logic [`PST_IDX_MSB:0] phase,
  input wire logic [`PST_IDX_MSB:0] rise,
  input wire logic [`PST_IDX_MSB:0] fall,
  // Pulse
  output logic pulse
);

  logic next_pulse;

  // Set on the rise phase, clear on the fall phase, fall wins a tie
  // Edges only ever land on their own phase, even when an index is rewritten
  // or the pulse is enabled mid-period; disable drops the pulse at once
  always_comb begin
    next_pulse = 1'b0;
    if (enable) begin
      if (phase == fall) begin
        next_pulse = 1'b0;
      end else if (phase == rise) begin
        next_pulse = 1'b1;
      end else begin
        next_pulse = pulse;
      end
    end
  end

  // Pulse register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= next_pulse;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/pst_pkg.sv */
// Purpose: Types shared by the pixel sampling timing configuration block
// Assumes: Constants come from pst_consts.svh
// Notes:   Bus request and pulse pair travel as packed structs
`default_nettype none
`include "pst_consts.svh"

package pst_pkg;

  // ----------------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [`PST_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pst_bus_s;

  typedef struct packed {
    logic restore;
    logic acquire;
  } pst_pulses_s;

  // ----------------------------------------------------------------------------
  // Loop model states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PST_LOOP_RESET,
    PST_LOOP_ACQUIRE,
    PST_LOOP_LOCKED,
    PST_LOOP_FALSE
  } pst_loop_e;

endpackage

`default_nettype wire

/* File: rtl/pst_timing.sv */
// Purpose: Timing configuration registers, loop model and sampling pulses
// Assumes: Register port is synchronous to clock; read data one cycle later
// Notes:   Pixel period is 64 phase steps of the local clock once locked
`default_nettype none
`include "pst_consts.svh"

module pst_timing (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire pst_pkg::pst_bus_s bus,
  output logic [7:0] rd_data,
  // Sampling pulses
  output pst_pkg::pst_pulses_s pulses,
  // Configuration seen by the analog path
  output logic [2:0] clock_band,
  output logic [1:0] loop_band,
  output logic sample_hold,
  output logic loop_reset,
  // Loop state
  output logic loop_locked,
  output logic false_lock,
  // Interrupt
  output logic irq
);

  import pst_pkg::*;

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  logic [7:0] sh_mode, rise_r, fall_r, rise_a, fall_a, band, loop_cfg;
  logic [7:0] next_sh_mode, next_rise_r, next_fall_r, next_rise_a, next_fall_a;
  logic [7:0] next_band, next_loop_cfg;
  logic rst_done;

  // Register writes; loop reset bit clears itself at end of reset
  always_comb begin
    next_sh_mode = sh_mode;
    next_rise_r = rise_r;
    next_fall_r = fall_r;
    next_rise_a = rise_a;
    next_fall_a = fall_a;
    next_band = band;
    next_loop_cfg = loop_cfg;
    if (rst_done) begin
      next_loop_cfg[`PST_LOOP_RST_BIT] = 1'b0;
    end
    if (bus.wr) begin
      case (bus.addr)
        `PST_OFS_SH_MODE: next_sh_mode = bus.wdata & `PST_MASK_SH_MODE;
        `PST_OFS_RISE_R: next_rise_r = bus.wdata & `PST_MASK_IDX;
        `PST_OFS_FALL_R: next_fall_r = bus.wdata & `PST_MASK_IDX;
        `PST_OFS_RISE_A: next_rise_a = bus.wdata & `PST_MASK_IDX;
        `PST_OFS_FALL_A: next_fall_a = bus.wdata & `PST_MASK_IDX;
        `PST_OFS_BAND: next_band = bus.wdata & `PST_MASK_BAND;
        `PST_OFS_LOOP_CFG: next_loop_cfg = bus.wdata;
        default: next_band = band;
      endcase
    end
  end

  // Register state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_mode <= `PST_RST_SH_MODE;
      rise_r <= `PST_RST_RISE_R;
      fall_r <= `PST_RST_FALL_R;
      rise_a <= `PST_RST_RISE_A;
      fall_a <= `PST_RST_FALL_A;
      band <= `PST_RST_BAND;
      loop_cfg <= `PST_RST_LOOP_CFG;
    end else begin
      sh_mode <= next_sh_mode;
      rise_r <= next_rise_r;
      fall_r <= next_fall_r;
      rise_a <= next_rise_a;
      fall_a <= next_fall_a;
      band <= next_band;
      loop_cfg <= next_loop_cfg;
    end
  end

  // Configuration outputs straight from the registers
  assign clock_band = band[`PST_BAND_MSB:`PST_BAND_LSB];
  assign loop_band = band[`PST_LOOP_MSB:`PST_LOOP_LSB];
  assign sample_hold = sh_mode[`PST_SH_BIT];
  assign loop_reset = loop_cfg[`PST_LOOP_RST_BIT];

  // ----------------------------------------------------------------------------
  // Loop model
  // ----------------------------------------------------------------------------
  pst_loop_e loop_state, next_loop_state;
  logic [`PST_CNT_W-1:0] loop_cnt, next_loop_cnt;
  logic next_loop_locked, next_false_lock;
  logic band_match, lock_done;

  // Loop range must cover the chosen clock band, else lock is false
  always_comb begin
    case (band[`PST_BAND_MSB:`PST_BAND_LSB])
      `PST_BAND_25_40, `PST_BAND_14_25:
        band_match = band[`PST_LOOP_MSB:`PST_LOOP_LSB] == `PST_LOOP_14_40;
      `PST_BAND_10_14, `PST_BAND_7P5_10:
        band_match = band[`PST_LOOP_MSB:`PST_LOOP_LSB] == `PST_LOOP_7P5_14;
      `PST_BAND_6_7P5, `PST_BAND_5_6:
        band_match = band[`PST_LOOP_MSB:`PST_LOOP_LSB] == `PST_LOOP_5_7P5;
      default: band_match = 1'b0;
    endcase
  end

  assign rst_done = (loop_state == PST_LOOP_RESET) &&
                    (loop_cnt == `PST_CNT_W'(`PST_LOOP_RST_CYC - 1));
  assign lock_done = (loop_state == PST_LOOP_ACQUIRE) &&
                     (loop_cnt == `PST_CNT_W'(`PST_LOCK_CYC - 1));

  // Reset, acquire, then settle true or false; reset bit restarts it
  always_comb begin
    next_loop_state = loop_state;
    next_loop_cnt = loop_cnt + `PST_CNT_W'(1);
    case (loop_state)
      PST_LOOP_RESET: begin
        if (rst_done) begin
          next_loop_state = PST_LOOP_ACQUIRE;
          next_loop_cnt = '0;
        end
      end
      PST_LOOP_ACQUIRE: begin
        if (lock_done) begin
          next_loop_state = band_match ? PST_LOOP_LOCKED : PST_LOOP_FALSE;
          next_loop_cnt = '0;
        end
      end
      PST_LOOP_LOCKED, PST_LOOP_FALSE: next_loop_cnt = '0;
      default: next_loop_state = PST_LOOP_RESET;
    endcase
    if (loop_cfg[`PST_LOOP_RST_BIT] && loop_state != PST_LOOP_RESET) begin
      next_loop_state = PST_LOOP_RESET;
      next_loop_cnt = '0;
    end
    next_loop_locked = next_loop_state == PST_LOOP_LOCKED;
    next_false_lock = next_loop_state == PST_LOOP_FALSE;
  end

  // Loop state registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loop_state <= PST_LOOP_RESET;
      loop_cnt <= '0;
      loop_locked <= 1'b0;
      false_lock <= 1'b0;
    end else begin
      loop_state <= next_loop_state;
      loop_cnt <= next_loop_cnt;
      loop_locked <= next_loop_locked;
      false_lock <= next_false_lock;
    end
  end

  // ----------------------------------------------------------------------------
  // Phase counter and pulse generators
  // ----------------------------------------------------------------------------
  logic [`PST_IDX_MSB:0] phase, next_phase;
  logic restore_en;

  // Phase steps one sixty-fourth of the period, from zero at lock
  always_comb begin
    next_phase = loop_locked ? phase + 6'h01 : 6'h00;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= 6'h00;
    end else begin
      phase <= next_phase;
    end
  end

  // Restore pulse silenced in sample-and-hold mode
  assign restore_en = loop_locked && !sh_mode[`PST_SH_BIT];

  pst_edge_gen u_restore (
    .clock(clock),
    .rst(rst),
    .enable(restore_en),
    .phase(phase),
    .rise(rise_r[`PST_IDX_MSB:0]),
    .fall(fall_r[`PST_IDX_MSB:0]),
    .pulse(pulses.restore)
  );

  pst_edge_gen u_acquire (
    .clock(clock),
    .rst(rst),
    .enable(loop_locked),
    .phase(phase),
    .rise(rise_a[`PST_IDX_MSB:0]),
    .fall(fall_a[`PST_IDX_MSB:0]),
    .pulse(pulses.acquire)
  );

  // ----------------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------------
  logic [7:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask, irq_set;
  logic next_irq;

  // Sticky events, write one to clear, set wins over clear
  always_comb begin
    irq_set = 8'h00;
    irq_set[`PST_IRQ_LOCK_BIT] = next_loop_locked && !loop_locked;
    irq_set[`PST_IRQ_FLOCK_BIT] = next_false_lock && !false_lock;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (bus.wr && bus.addr == `PST_OFS_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~bus.wdata;
    end
    if (bus.wr && bus.addr == `PST_OFS_IRQ_MASK) begin
      next_irq_mask = bus.wdata & `PST_MASK_IRQ;
    end
    next_irq_stat = next_irq_stat | irq_set;
    next_irq = |(irq_stat & irq_mask);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat <= `PST_RST_IRQ;
      irq_mask <= `PST_RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  logic [7:0] next_rd_data;

  // Read mux; unmapped offsets and idle cycles give zero
  always_comb begin
    next_rd_data = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `PST_OFS_SH_MODE: next_rd_data = sh_mode;
        `PST_OFS_STATUS: next_rd_data[`PST_FLOCK_BIT] = false_lock;
        `PST_OFS_RISE_R: next_rd_data = rise_r;
        `PST_OFS_FALL_R: next_rd_data = fall_r;
        `PST_OFS_RISE_A: next_rd_data = rise_a;
        `PST_OFS_FALL_A: next_rd_data = fall_a;
        `PST_OFS_BAND: next_rd_data = band;
        `PST_OFS_LOOP_CFG: next_rd_data = loop_cfg;
        `PST_OFS_IRQ_STAT: next_rd_data = irq_stat;
        `PST_OFS_IRQ_MASK: next_rd_data = irq_mask;
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  localparam int RST_LIMIT = `PST_LOOP_RST_CYC + 2;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  mode_sh_quiet_a: assert property (
    sh_mode[`PST_SH_BIT] |=> !pulses.restore
  ) else $error("restore pulse active in sample-and-hold mode");

  restore_rise_a: assert property (
    $rose(pulses.restore) |-> $past(phase) == $past(rise_r[`PST_IDX_MSB:0])
  ) else $error("restore pulse rose at wrong phase");

  restore_fall_a: assert property (
    $fell(pulses.restore) && $past(restore_en) |->
      $past(phase) == $past(fall_r[`PST_IDX_MSB:0])
  ) else $error("restore pulse fell at wrong phase");

  acquire_rise_a: assert property (
    $rose(pulses.acquire) |-> $past(phase) == $past(rise_a[`PST_IDX_MSB:0])
  ) else $error("acquire pulse rose at wrong phase");

  acquire_fall_a: assert property (
    $fell(pulses.acquire) && $past(loop_locked) |->
      $past(phase) == $past(fall_a[`PST_IDX_MSB:0])
  ) else $error("acquire pulse fell at wrong phase");

  loop_selfclear_a: assert property (
    $rose(loop_cfg[`PST_LOOP_RST_BIT]) |-> ##[1:RST_LIMIT] !loop_cfg[`PST_LOOP_RST_BIT]
  ) else $error("loop reset bit did not clear itself");

  false_lock_a: assert property (
    lock_done && !band_match && !loop_cfg[`PST_LOOP_RST_BIT] |=> false_lock && !loop_locked
  ) else $error("band mismatch did not flag false lock");

  band_lock_a: assert property (
    lock_done && band_match && !loop_cfg[`PST_LOOP_RST_BIT] |=> loop_locked ##1 phase == 6'h01
  ) else $error("matching bands did not lock and start phase");

  status_read_a: assert property (
    bus.rd && bus.addr == `PST_OFS_STATUS |=> rd_data == {7'h00, $past(false_lock)}
  ) else $error("status read does not show false lock");

  phase_step_a: assert property (
    loop_locked && $past(loop_locked) |-> phase == $past(phase) + 6'h01
  ) else $error("phase did not advance by one step");

endmodule

`default_nettype wire
